//--- prog_pkg.sv
// constants shared by the serial programming port design
package prog_pkg;

   // ---------------------------------------------------------------
   // memory geometry
   // ---------------------------------------------------------------
   localparam int FLASH_ADDR_W = 14;   // word address width
   localparam int PAGE_W       = 6;    // word-in-page bits
   localparam int EE_ADDR_W    = 10;

   // ---------------------------------------------------------------
   // instruction framing
   // ---------------------------------------------------------------
   localparam int          INSTR_BITS   = 32;
   localparam logic [4:0]  ECHO_AT_CNT  = 5'h10;  // byte 2 done
   localparam logic [4:0]  READ_AT_CNT  = 5'h18;  // byte 3 done
   localparam logic [4:0]  LAST_BIT_CNT = 5'h1f;

   // ---------------------------------------------------------------
   // opcodes
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_ENABLE_B1   = 8'hac;
   localparam logic [7:0] OP_ENABLE_B2   = 8'h53;
   localparam logic [2:0] OP_ERASE_B2HI  = 3'h4;
   localparam logic [3:0] OP_RD_FLASH_HI = 4'h2;
   localparam logic [3:0] OP_LD_PAGE_HI  = 4'h4;
   localparam logic [7:0] OP_WR_PAGE     = 8'h4c;
   localparam logic [7:0] OP_RD_EE       = 8'ha0;
   localparam logic [7:0] OP_WR_EE       = 8'hc0;
   localparam logic [7:0] ERASED_BYTE    = 8'hff;
   localparam logic [7:0] IDLE_BYTE      = 8'h00;

   // ---------------------------------------------------------------
   // self-timed write durations
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 50;
   localparam int FLASH_WAIT_NS   = 4_500_000;
   localparam int EEPROM_WAIT_NS  = 9_000_000;
   localparam int ERASE_WAIT_NS   = 9_000_000;
   localparam int FLASH_WAIT_CYC  = FLASH_WAIT_NS / CLK_PERIOD_NS;
   localparam int EEPROM_WAIT_CYC = EEPROM_WAIT_NS / CLK_PERIOD_NS;
   localparam int ERASE_WAIT_CYC  = ERASE_WAIT_NS / CLK_PERIOD_NS;
   localparam int TIMER_W         = 18;

   typedef enum logic [1:0] {
      JOB_FLASH,
      JOB_EEPROM,
      JOB_ERASE
   } job_t;

endpackage

//--- level_sync.sv
// two-flop synchroniser for a single level
`timescale 1ns/10ps
`default_nettype none
module level_sync (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic d_in,
   output logic      q_out
);
   logic meta_q;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_q <= 1'b0;
         q_out  <= 1'b0;
      end else begin
         meta_q <= d_in;
         q_out  <= meta_q;
      end
   end
endmodule
`default_nettype wire

//--- write_timer.sv
// cpu-clock timer for self-timed nonvolatile writes, started by toggle
`timescale 1ns/10ps
`default_nettype none
module write_timer
   import prog_pkg::*;
#(
   parameter int FLASH_CYC  = FLASH_WAIT_CYC,
   parameter int EEPROM_CYC = EEPROM_WAIT_CYC,
   parameter int ERASE_CYC  = ERASE_WAIT_CYC
) (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic start_tgl_in,
   input  wire job_t job_in,
   output logic      busy_out
);
   logic               tgl_s;
   logic               tgl_seen_q;
   logic [TIMER_W-1:0] cnt_q;
   logic [TIMER_W-1:0] load_val;
   wire                start = tgl_s ^ tgl_seen_q;

   // job is stable for the whole crossing, so it is read only on start
   assign load_val = (job_in == JOB_FLASH)  ? TIMER_W'(FLASH_CYC)  :
                     (job_in == JOB_EEPROM) ? TIMER_W'(EEPROM_CYC) :
                                              TIMER_W'(ERASE_CYC);

   level_sync u_tgl (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .d_in     (start_tgl_in),
      .q_out    (tgl_s)
   );

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tgl_seen_q <= 1'b0;
         cnt_q      <= '0;
      end else begin
         tgl_seen_q <= tgl_s;
         if (start) begin
            cnt_q <= load_val;
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - TIMER_W'(1);
         end
      end
   end

   assign busy_out = (cnt_q != '0);
endmodule
`default_nettype wire

//--- serial_prog_port.sv
// serial programming port: instruction shifter, memories and write control
`timescale 1ns/10ps
`default_nettype none
module serial_prog_port
   import prog_pkg::*;
#(
   parameter int FLASH_CYC  = FLASH_WAIT_CYC,
   parameter int EEPROM_CYC = EEPROM_WAIT_CYC,
   parameter int ERASE_CYC  = ERASE_WAIT_CYC,
   parameter int FLASH_AW   = FLASH_ADDR_W,
   parameter int EE_AW      = EE_ADDR_W
) (
   input  wire logic CLOCK_IN,
   input  wire logic RESETN_IN,
   input  wire logic PROG_RESETN_IN,
   input  wire logic SCK_IN,
   input  wire logic MOSI_IN,
   output logic      MISO_OUT,
   output logic      MISO_OE_OUT,
   output logic      PROG_ENABLED_OUT,
   output logic      PROG_BUSY_OUT,
   output logic      NORMAL_RUN_OUT
);

   // ---------------------------------------------------------------
   // parameter checks
   // ---------------------------------------------------------------
   if (FLASH_CYC < 1 || FLASH_CYC >= 2**TIMER_W ||
       EEPROM_CYC < 1 || EEPROM_CYC >= 2**TIMER_W ||
       ERASE_CYC < 1 || ERASE_CYC >= 2**TIMER_W) begin : g_bad_time
      $error("write time does not fit the timer");
   end
   if (FLASH_AW <= PAGE_W || FLASH_AW > 14 || EE_AW < 1 || EE_AW > 10) begin : g_bad_size
      $error("memory size not servable by the instruction format");
   end

   localparam int FLASH_WORDS = 2**FLASH_AW;
   localparam int EE_BYTES    = 2**EE_AW;
   localparam int PAGE_WORDS  = 2**PAGE_W;
   localparam int PAGE_SEL_W  = FLASH_AW - PAGE_W;

   // ---------------------------------------------------------------
   // cpu-clock reset and pin synchronisation
   // ---------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n;
   logic prog_pin_s;
   logic prog_active_q;
   logic link_rst_n;
   logic busy_cpu;
   logic enabled_link_q;
   logic [1:0] pin_settle_q;

   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // the pin is sampled inverted so the synchroniser resets to "not programming"
   level_sync u_prog_pin (
      .clk_in   (CLOCK_IN),
      .rst_n_in (rst_n),
      .d_in     (~PROG_RESETN_IN),
      .q_out    (prog_pin_s)
   );

   // pin synchroniser reads "not programming" straight out of reset; normal run
   // must not start until it has really seen the pin, or a held pin glitches it
   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         pin_settle_q <= 2'h0;
      end else begin
         pin_settle_q <= {pin_settle_q[0], 1'b1};
      end
   end

   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         prog_active_q <= 1'b0;
      end else begin
         prog_active_q <= prog_pin_s;
      end
   end

   // reset pulse drops sync
   // link logic is held in reset whenever the programming window is closed;
   // this is the only way to regain bit alignment after a lost clock edge
   assign link_rst_n = rst_n & prog_active_q;

   assign NORMAL_RUN_OUT = pin_settle_q[1] & ~prog_pin_s & ~prog_active_q;

   level_sync u_enabled (
      .clk_in   (CLOCK_IN),
      .rst_n_in (rst_n),
      .d_in     (enabled_link_q),
      .q_out    (PROG_ENABLED_OUT)
   );

   // ---------------------------------------------------------------
   // link domain: instruction shifter
   // ---------------------------------------------------------------
   logic [31:0] sh_q;
   logic [4:0]  cnt_q;
   logic [31:0] word;
   logic        word_done;
   logic        busy_link;
   logic        pend_q;
   logic        start_tgl_q;
   job_t        job_q;

   assign word      = {sh_q[30:0], MOSI_IN};
   assign word_done = (cnt_q == LAST_BIT_CNT);

   always_ff @(posedge SCK_IN or negedge link_rst_n) begin
      if (!link_rst_n) begin
         sh_q  <= '0;
         cnt_q <= '0;
      end else begin
         sh_q  <= word;
         cnt_q <= cnt_q + 5'h01;
      end
   end

   // ---------------------------------------------------------------
   // instruction decode
   // ---------------------------------------------------------------
   function automatic logic [FLASH_AW-1:0] flash_addr(input logic [7:0] b2, input logic [7:0] b3);
      logic [13:0] full;
      full       = {b2[5:0], b3};
      flash_addr = full[FLASH_AW-1:0];
   endfunction

   function automatic logic [EE_AW-1:0] ee_addr(input logic [7:0] b2, input logic [7:0] b3);
      logic [9:0] full;
      full    = {b2[1:0], b3};
      ee_addr = full[EE_AW-1:0];
   endfunction

   wire [7:0] b1 = word[31:24];
   wire [7:0] b2 = word[23:16];
   wire [7:0] b3 = word[15:8];
   wire [7:0] b4 = word[7:0];

   wire is_enable  = word_done && (b1 == OP_ENABLE_B1) && (b2 == OP_ENABLE_B2);
   wire is_erase   = word_done && (b1 == OP_ENABLE_B1) && (b2[7:5] == OP_ERASE_B2HI);
   wire is_ld_page = word_done && (b1[7:4] == OP_LD_PAGE_HI) && (b1[2:0] == 3'h0);
   wire is_wr_page = word_done && (b1 == OP_WR_PAGE);
   wire is_wr_ee   = word_done && (b1 == OP_WR_EE);

   wire do_erase   = is_erase   && enabled_link_q;
   wire do_ld_page = is_ld_page && enabled_link_q;
   wire do_wr_page = is_wr_page && enabled_link_q;
   wire do_wr_ee   = is_wr_ee   && enabled_link_q;

   wire [FLASH_AW-1:0]   wr_faddr  = flash_addr(b2, b3);
   wire [PAGE_SEL_W-1:0] wr_page   = wr_faddr[FLASH_AW-1:PAGE_W];
   wire [PAGE_W-1:0]     ld_index  = b3[PAGE_W-1:0];
   wire [EE_AW-1:0]      wr_eaddr  = ee_addr(b2, b3);

   always_ff @(posedge SCK_IN or negedge link_rst_n) begin
      if (!link_rst_n) begin
         enabled_link_q <= 1'b0;
      end else if (is_enable) begin
         enabled_link_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // memories
   // ---------------------------------------------------------------
   logic [7:0] flash_lo [FLASH_WORDS];
   logic [7:0] flash_hi [FLASH_WORDS];
   logic [7:0] page_lo  [PAGE_WORDS];
   logic [7:0] page_hi  [PAGE_WORDS];
   logic [7:0] ee_mem   [EE_BYTES];

   // arrays carry no reset; contents survive leaving programming mode
   always_ff @(posedge SCK_IN) begin
      if (do_erase) begin
         for (int i = 0; i < FLASH_WORDS; i++) begin
            flash_lo[i] <= ERASED_BYTE;
            flash_hi[i] <= ERASED_BYTE;
         end
         for (int i = 0; i < EE_BYTES; i++) begin
            ee_mem[i] <= ERASED_BYTE;
         end
      end
      if (do_ld_page) begin
         if (b1[3]) begin
            page_hi[ld_index] <= b4;
         end else begin
            page_lo[ld_index] <= b4;
         end
      end
      if (do_wr_page) begin
         for (int i = 0; i < PAGE_WORDS; i++) begin
            flash_lo[{wr_page, PAGE_W'(i)}] <= page_lo[i];
            flash_hi[{wr_page, PAGE_W'(i)}] <= page_hi[i];
         end
      end
      if (do_wr_ee) begin
         ee_mem[wr_eaddr] <= b4;
      end
   end

   // ---------------------------------------------------------------
   // self-timed write tracking
   // ---------------------------------------------------------------
   logic [PAGE_SEL_W-1:0] busy_page_q;
   logic [EE_AW-1:0]      busy_ee_q;
   logic                  busy_is_flash_q;
   logic                  busy_mask;
   wire                   start_job = do_erase | do_wr_page | do_wr_ee;

   // pend covers the gap until the cpu-side timer reports busy back
   always_ff @(posedge SCK_IN or negedge link_rst_n) begin
      if (!link_rst_n) begin
         start_tgl_q     <= 1'b0;
         job_q           <= JOB_FLASH;
         pend_q          <= 1'b0;
         busy_page_q     <= '0;
         busy_ee_q       <= '0;
         busy_is_flash_q <= 1'b0;
      end else if (start_job) begin
         start_tgl_q     <= ~start_tgl_q;
         job_q           <= do_erase ? JOB_ERASE : (do_wr_page ? JOB_FLASH : JOB_EEPROM);
         pend_q          <= 1'b1;
         busy_page_q     <= wr_page;
         busy_ee_q       <= wr_eaddr;
         busy_is_flash_q <= do_wr_page;
      end else if (busy_link) begin
         pend_q <= 1'b0;
      end
   end

   write_timer #(
      .FLASH_CYC  (FLASH_CYC),
      .EEPROM_CYC (EEPROM_CYC),
      .ERASE_CYC  (ERASE_CYC)
   ) u_timer (
      .clk_in       (CLOCK_IN),
      .rst_n_in     (rst_n),
      .start_tgl_in (start_tgl_q),
      .job_in       (job_q),
      .busy_out     (busy_cpu)
   );

   assign PROG_BUSY_OUT = busy_cpu;

   // only advances on serial clock edges, which polling reads supply
   level_sync u_busy_link (
      .clk_in   (SCK_IN),
      .rst_n_in (link_rst_n),
      .d_in     (busy_cpu),
      .q_out    (busy_link)
   );

   assign busy_mask = pend_q | busy_link;

   // ---------------------------------------------------------------
   // read path: answered from the first three bytes
   // ---------------------------------------------------------------
   wire [7:0]          rb1     = sh_q[23:16];
   wire [7:0]          rb2     = sh_q[15:8];
   wire [7:0]          rb3     = sh_q[7:0];
   wire [FLASH_AW-1:0] rd_fa   = flash_addr(rb2, rb3);
   wire [EE_AW-1:0]    rd_ea   = ee_addr(rb2, rb3);
   wire                rd_fl   = (rb1[7:4] == OP_RD_FLASH_HI) && (rb1[2:0] == 3'h0);
   wire                rd_ee   = (rb1 == OP_RD_EE);
   wire [7:0]          fl_byte = rb1[3] ? flash_hi[rd_fa] : flash_lo[rd_fa];

   wire fl_masked = busy_mask && busy_is_flash_q &&
                    (job_q == JOB_FLASH) && (rd_fa[FLASH_AW-1:PAGE_W] == busy_page_q);
   wire ee_masked = busy_mask && !busy_is_flash_q &&
                    ((job_q == JOB_ERASE) || (rd_ea == busy_ee_q));

   wire [7:0] rd_byte = !enabled_link_q ? IDLE_BYTE :
                        rd_fl ? (fl_masked || (busy_mask && job_q == JOB_ERASE) ? ERASED_BYTE : fl_byte) :
                        rd_ee ? (ee_masked ? ERASED_BYTE : ee_mem[rd_ea]) :
                                IDLE_BYTE;

   // ---------------------------------------------------------------
   // output shifter
   // ---------------------------------------------------------------
   logic [7:0] out_q;

   always_ff @(negedge SCK_IN or negedge link_rst_n) begin
      if (!link_rst_n) begin
         out_q <= IDLE_BYTE;
      end else if (cnt_q == ECHO_AT_CNT) begin
         out_q <= sh_q[7:0];
      end else if (cnt_q == READ_AT_CNT) begin
         out_q <= rd_byte;
      end else begin
         out_q <= {out_q[6:0], 1'b0};
      end
   end

   assign MISO_OUT    = out_q[7];
   assign MISO_OE_OUT = prog_active_q;

endmodule
`default_nettype wire

//--- spp_checker.sv
// assertion checker for the serial programming port pins
`timescale 1ns/10ps
`default_nettype none
module spp_checker
   import prog_pkg::*;
#(
   parameter int FLASH_CYC  = FLASH_WAIT_CYC,
   parameter int EEPROM_CYC = EEPROM_WAIT_CYC,
   parameter int ERASE_CYC  = ERASE_WAIT_CYC,
   parameter int FLASH_AW   = FLASH_ADDR_W,
   parameter int EE_AW      = EE_ADDR_W
) (
   input wire logic CLOCK_IN,
   input wire logic RESETN_IN,
   input wire logic PROG_RESETN_IN,
   input wire logic SCK_IN,
   input wire logic MOSI_IN,
   input wire logic MISO_OUT,
   input wire logic MISO_OE_OUT,
   input wire logic PROG_ENABLED_OUT,
   input wire logic PROG_BUSY_OUT,
   input wire logic NORMAL_RUN_OUT
);
   // ----------
   // helpers
   // ----------
   logic [TIMER_W-1:0] busy_cnt_q;
   logic               miso_hi_q;
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         busy_cnt_q <= '0;
      end else begin
         busy_cnt_q <= PROG_BUSY_OUT ? busy_cnt_q + 1'b1 : '0;
      end
   end
   // bit seen at the rise must still stand at the fall
   always_ff @(posedge SCK_IN) begin
      miso_hi_q <= MISO_OUT;
   end
   // ----------
   // properties
   // ----------
   property p_oe_open;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN) !PROG_RESETN_IN [*8] |-> MISO_OE_OUT;
   endproperty
   a_oe_open: assert property (p_oe_open) else $error("pin not driven in window");
   property p_oe_close;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN) PROG_RESETN_IN [*4] |-> !MISO_OE_OUT;
   endproperty
   a_oe_close: assert property (p_oe_close) else $error("pin driven outside window");
   property p_miso_idle;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN) !MISO_OE_OUT |-> !MISO_OUT;
   endproperty
   a_miso_idle: assert property (p_miso_idle) else $error("data out not low when idle");
   property p_run_open;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN) PROG_RESETN_IN [*8] |-> NORMAL_RUN_OUT;
   endproperty
   a_run_open: assert property (p_run_open) else $error("normal run not started");
   property p_run_close;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN) !PROG_RESETN_IN [*4] |-> !NORMAL_RUN_OUT;
   endproperty
   a_run_close: assert property (p_run_close) else $error("normal run during window");
   property p_en_lost;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN) PROG_RESETN_IN |-> ##8 !PROG_ENABLED_OUT;
   endproperty
   a_en_lost: assert property (p_en_lost) else $error("enable kept after window");
   property p_busy_cause;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN) $rose(PROG_BUSY_OUT) |-> PROG_ENABLED_OUT;
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("write started without enable");
   property p_busy_len;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN) $fell(PROG_BUSY_OUT) |->
         busy_cnt_q inside {[FLASH_CYC-1:FLASH_CYC+1], [EEPROM_CYC-1:EEPROM_CYC+1], [ERASE_CYC-1:ERASE_CYC+1]};
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("write time wrong");
   property p_miso_edge;
      @(negedge SCK_IN) disable iff (!RESETN_IN || PROG_RESETN_IN) MISO_OUT == miso_hi_q;
   endproperty
   a_miso_edge: assert property (p_miso_edge) else $error("data out moved while clock high");
endmodule
`default_nettype wire

//--- prog_model.sv
// external programmer model: makes the serial clock, sends and samples bits
`timescale 1ns/10ps
`default_nettype none
module prog_model #(
   // phase width per half period
   // short phases are safe only because the link logic runs on this clock itself
   parameter time HALF = 15
) (
   output logic      sck_out,
   output logic      mosi_out,
   input  wire logic miso_in
);
   initial begin
      sck_out  = 1'b0;
      mosi_out = 1'b1;
   end
   task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
      rsp = '0;
      #7;
      for (int i = 31; i >= 0; i--) begin
         // msb first, set up while low
         mosi_out = cmd[i];
         #HALF sck_out = 1'b1;
         // taken at the rise after the fall
         rsp = {rsp[30:0], miso_in};
         #HALF sck_out = 1'b0;
      end
      // stale bit inverted so it is never read as valid
      #HALF mosi_out = ~mosi_out;
   endtask
endmodule
`default_nettype wire

//--- test_serial_prog_port.sv
// self-checking bench for the serial programming port
`timescale 1ns/10ps
`default_nettype none
module test_serial_prog_port;
   import prog_pkg::*;
   // short self-timed writes keep the run brief
   localparam int FCYC = 30;
   localparam int ECYC = 50;
   // power-up wait before enable, scaled down like the write times
   localparam int PWR_CYC = 20;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   // device reset held low from power-up
   logic        prstn = 1'b0;
   wire logic   sck;
   wire logic   mosi;
   logic        miso;
   logic        oe;
   logic        en;
   logic        busy;
   logic        run;
   logic [3:0]  obs;
   logic [31:0] rsp;
   int          fail_count = 0;
   int          cmp_count = 0;
   assign obs = {run, busy, en, oe};
   always #25 clk = ~clk;
   serial_prog_port #(.FLASH_CYC(FCYC), .EEPROM_CYC(ECYC), .ERASE_CYC(ECYC)) dut_u (
      .CLOCK_IN(clk), .RESETN_IN(rstn), .PROG_RESETN_IN(prstn), .SCK_IN(sck), .MOSI_IN(mosi),
      .MISO_OUT(miso), .MISO_OE_OUT(oe), .PROG_ENABLED_OUT(en), .PROG_BUSY_OUT(busy), .NORMAL_RUN_OUT(run));
   prog_model prog_u (.sck_out(sck), .mosi_out(mosi), .miso_in(miso));
   // ----------
   // shared tasks
   // ----------
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask
   // status bit i: 0 drive, 1 enabled, 2 busy, 3 run
   task automatic wait_for(input int i, input logic lvl);
      int n;
      n = 0;
      while (obs[i] !== lvl && n < 400) begin
         @(posedge clk);
         n++;
      end
      if (obs[i] !== lvl) begin
         fail_count++;
         $display("unexpected at %0t: status %0d stuck", $time, i);
         conclude();
      end
   endtask
   // ----------
   // scenarios
   // ----------
   task automatic s_refused();
      wait_for(0, 1'b1);
      chk({7'h0, run}, 8'h00);
      prog_u.xfer(32'hac800000, rsp);
      repeat (10) @(posedge clk);
      chk({7'h0, busy}, 8'h00);
      prog_u.xfer(32'ha0000300, rsp);
      chk(rsp[7:0], IDLE_BYTE);
   endtask
   task automatic s_enable();
      repeat (PWR_CYC) @(posedge clk);
      prog_u.xfer({OP_ENABLE_B1, OP_ENABLE_B2, 16'h0000}, rsp);
      chk(rsp[15:8], OP_ENABLE_B2);
      chk(rsp[31:24], IDLE_BYTE);
      wait_for(1, 1'b1);
   endtask
   task automatic s_erase();
      prog_u.xfer(32'hac800000, rsp);
      wait_for(2, 1'b1);
      prog_u.xfer(32'ha0000100, rsp);
      chk(rsp[7:0], ERASED_BYTE);
      wait_for(2, 1'b0);
      prog_u.xfer(32'ha003ff00, rsp);
      chk(rsp[7:0], ERASED_BYTE);
      prog_u.xfer(32'h283fff00, rsp);
      chk(rsp[7:0], ERASED_BYTE);
   endtask
   // second value clears bits the first one set
   task automatic s_eeprom();
      for (int k = 0; k < 2; k++) begin
         prog_u.xfer({OP_WR_EE, 16'h02a5, k ? 8'h3c : 8'ha5}, rsp);
         prog_u.xfer({OP_RD_EE, 16'h02a5, 8'h00}, rsp);
         chk(rsp[7:0], ERASED_BYTE);
         wait_for(2, 1'b0);
         prog_u.xfer({OP_RD_EE, 16'h02a5, 8'h00}, rsp);
         chk(rsp[7:0], k ? 8'h3c : 8'ha5);
      end
   endtask
   // word 5 of page 1, low byte loaded first
   task automatic s_flash();
      prog_u.xfer(32'h40000512, rsp);
      prog_u.xfer(32'h48000534, rsp);
      prog_u.xfer(32'h4c004000, rsp);
      prog_u.xfer(32'h20004600, rsp);
      chk(rsp[7:0], ERASED_BYTE);
      wait_for(2, 1'b0);
      prog_u.xfer(32'h20004500, rsp);
      chk(rsp[7:0], 8'h12);
      prog_u.xfer(32'h28004500, rsp);
      chk(rsp[7:0], 8'h34);
   endtask
   task automatic s_close();
      @(posedge clk);
      #2 prstn = 1'b1;
      wait_for(3, 1'b1);
      wait_for(1, 1'b0);
      chk({7'h0, oe}, 8'h00);
      @(posedge clk);
      #2 prstn = 1'b0;
      wait_for(0, 1'b1);
      prog_u.xfer(32'hc002a500, rsp);
      repeat (10) @(posedge clk);
      chk({7'h0, busy}, 8'h00);
      s_enable();
      prog_u.xfer({OP_RD_EE, 16'h02a5, 8'h00}, rsp);
      chk(rsp[7:0], 8'h3c);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #2 rstn = 1'b1;
      s_refused();
      s_enable();
      s_erase();
      s_eeprom();
      s_flash();
      s_close();
      conclude();
   end
endmodule
bind serial_prog_port spp_checker #(.FLASH_CYC(FLASH_CYC), .EEPROM_CYC(EEPROM_CYC), .ERASE_CYC(ERASE_CYC),
   .FLASH_AW(FLASH_AW), .EE_AW(EE_AW)) chk_u (.CLOCK_IN(CLOCK_IN), .RESETN_IN(RESETN_IN),
   .PROG_RESETN_IN(PROG_RESETN_IN), .SCK_IN(SCK_IN), .MOSI_IN(MOSI_IN), .MISO_OUT(MISO_OUT),
   .MISO_OE_OUT(MISO_OE_OUT), .PROG_ENABLED_OUT(PROG_ENABLED_OUT), .PROG_BUSY_OUT(PROG_BUSY_OUT),
   .NORMAL_RUN_OUT(NORMAL_RUN_OUT));
`default_nettype wire
